// ===== logic/sensor_operational_control.v
`timescale 1ns/1ps
`include "sensor_operational_control_regs.vh"
module sensor_operational_control #(
  parameter integer WAKE_CYC  = `T_WAKE_US * `CLK_PER_US,
  parameter integer RESET_CYC = `T_RESET_US * `CLK_PER_US,
  parameter integer SAVE_CYC  = `T_SAVE_US * `CLK_PER_US,
  parameter integer LONG_CYC  = `T_LONG_US * `CLK_PER_US,
  parameter integer BASE_DIV  = `CLK_HZ / `BASE_HZ
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        sclk,           // Serial clock pin
  input  wire        cs_n,           // Chip select pin
  input  wire        mosi,           // Serial data in
  output reg         miso,           // Serial data out
  input  wire        supply_over,    // Supply above high limit
  input  wire        supply_under,   // Supply below low limit
  input  wire        checksum_bad,   // Program sum mismatch
  input  wire        alarm1,         // Alarm one active
  input  wire        alarm2,         // Alarm two active
  input  wire        buffer_full,    // Capture buffer full
  input  wire        selftest_fail,  // Self-test failed
  input  wire        selftest_busy,  // Self-test running
  input  wire        nv_fail,        // Nonvolatile update failed
  input  wire        line1_in,       // Digital line one input level
  input  wire        line2_in,       // Digital line two input level
  output reg         line1_out,      // Digital line one drive level
  output reg         line1_oe,       // Digital line one enable
  output reg         line2_out,      // Digital line two drive level
  output reg         line2_oe,       // Digital line two enable
  output reg         sample_tick,    // One pulse per sample
  output reg         data_ready,     // Internal data-ready level
  output reg         standby,        // Low-power standby
  output reg         busy,           // Command pause in progress
  output reg  [8:0]  cmd_pulse,      // One pulse per command start
  output reg         selftest_apply, // Self-test stimulus
  output reg         selftest_skip,  // No startup self-test
  output reg         peak_sum_en,    // Sum-of-squares peak enable
  output reg         peak_axis_en,   // Per-axis peak enable
  output reg  [9:0]  x_trim,         // X offset trim
  output reg  [9:0]  y_trim,         // Y offset trim
  output reg  [9:0]  z_trim          // Z offset trim
);
  // ==========================================================
  // Pin synchronisers
  reg  [2:0] sclk_s;     // Serial clock sync plus edge stage
  reg  [1:0] cs_s;       // Chip select sync
  reg  [1:0] mosi_s;     // Data sync
  reg  [1:0] l1_s;       // Line one input sync
  reg  [1:0] l2_s;       // Line two input sync
  reg        cs_d;       // Delayed chip select for edge
  wire       sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire       sclk_fall = ~sclk_s[1] & sclk_s[2];
  wire       cs_rise   = cs_s[1] & ~cs_d;

  // Two flops before any logic reads pins
  always @(posedge clk)
  begin
    if (rst)
    begin
      sclk_s <= 3'h0;
      cs_s   <= 2'h3;
      cs_d   <= 1'b1;
      mosi_s <= 2'h0;
      l1_s   <= 2'h0;
      l2_s   <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], sclk};
      cs_s   <= {cs_s[0], cs_n};
      cs_d   <= cs_s[1];
      mosi_s <= {mosi_s[0], mosi};
      l1_s   <= {l1_s[0], line1_in};
      l2_s   <= {l2_s[0], line2_in};
    end
  end

  // ==========================================================
  // Registers
  reg  [15:0] sample_period;        // Rate divisor
  reg  [15:0] misc_control;         // Data-ready and self-test
  reg  [15:0] general_line_control; // Line direction and level
  reg  [15:0] alarm_routing_control;// Alarm line routing
  reg  [15:0] diagnostic_flags;     // Clear-on-read flags
  reg  [15:0] x_off;                // Full trim registers
  reg  [15:0] y_off;
  reg  [15:0] z_off;
  reg  [8:0]  global_command;       // Pending command bits

  // ==========================================================
  // Serial shift engine
  reg  [15:0] shift_in;   // Incoming word
  reg  [15:0] shift_out;  // Outgoing word
  reg  [3:0]  bit_cnt;    // Edges modulo 16
  reg         word_done;  // Sixteenth edge seen
  reg         rd_diag;    // Diagnostic read in progress
  wire [15:0] word_now = {shift_in[14:0], mosi_s[1]};
  reg  [15:0] read_data;  // Muxed read value

  // Read mux on the address of the word just received, so the
  // next frame carries the data that this frame asked for
  always @*
  begin
    case ({word_now[14:9], 1'b0})
      `ADR_DIAG:   read_data = diagnostic_flags;
      `ADR_X_OFF:  read_data = x_off;
      `ADR_Y_OFF:  read_data = y_off;
      `ADR_Z_OFF:  read_data = z_off;
      `ADR_ALARM:  read_data = alarm_routing_control;
      `ADR_GPIO:   read_data = general_line_control;
      `ADR_MISC:   read_data = misc_control;
      `ADR_PERIOD: read_data = sample_period;
      default:     read_data = `RST_ZERO; // Unmapped reads zero
    endcase
  end

  // Per-byte write helper
  function [15:0] put_byte;
    input [15:0] old;
    input        hi;
    input [7:0]  d;
    begin
      put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
    end
  endfunction

  // ==========================================================
  // Pause timer, commands suspend serial and sampling
  reg  [26:0] pause_cnt;  // Remaining pause cycles
  reg  [26:0] next_pause; // Pause length for new commands
  wire [7:0]  wd = word_now[7:0];
  wire        wr_hi = word_now[8];
  wire [6:0]  wa = word_now[14:8];

  // Longest pause among started commands
  always @*
  begin
    next_pause = 27'h0;
    if (wd[`CMD_ERASE] | wd[`CMD_FACTORY])
      next_pause = LONG_CYC[26:0];
    else if (wd[`CMD_SWRESET])
      next_pause = RESET_CYC[26:0];
    else if (wd[`CMD_SAVE])
      next_pause = SAVE_CYC[26:0];
    if (wr_hi && wd[0] && next_pause == 27'h0)
      next_pause = WAKE_CYC[26:0];
    else if (wr_hi)
      next_pause = 27'h0;
  end

  // Pause begins at this very edge; sampling must halt now, not a cycle late
  wire pause_start = !cs_s[1] && !busy && sclk_rise && bit_cnt == 4'hF &&
                     word_now[15] && ({wa[6:1], 1'b0} == `ADR_CMD) &&
                     next_pause != 27'h0;

  // Frame handling and register writes
  always @(posedge clk)
  begin
    if (rst || (busy && pause_cnt == 27'h1 && global_command[`CMD_SWRESET]))
    begin
      shift_in <= 16'h0;
      shift_out <= 16'h0;
      bit_cnt <= 4'h0;
      word_done <= 1'b0;
      rd_diag <= 1'b0;
      miso <= 1'b0;
      sample_period <= `RST_PERIOD;
      misc_control <= `RST_MISC;
      general_line_control <= `RST_ZERO;
      alarm_routing_control <= `RST_ZERO;
      x_off <= `RST_ZERO;
      y_off <= `RST_ZERO;
      z_off <= `RST_ZERO;
      global_command <= 9'h0;
      pause_cnt <= 27'h0;
      busy <= 1'b0;
      cmd_pulse <= 9'h0;
      standby <= 1'b0;
    end
    else
    begin
      word_done <= 1'b0;
      cmd_pulse <= 9'h0;
      rd_diag <= 1'b0;
      // Pause countdown, command bits clear at end
      if (busy)
      begin
        if (pause_cnt <= 27'h1)
        begin
          busy <= 1'b0;
          global_command <= 9'h0;
        end
        pause_cnt <= pause_cnt - 27'h1;
      end
      else if (|global_command)
        global_command <= 9'h0; // instant commands finish at once
      if (cs_s[1])
        bit_cnt <= 4'h0;
      else if (!busy && sclk_fall)
        miso <= shift_out[15];
      else if (!busy && sclk_rise)
      begin
        // Ignored while paused
        shift_in <= word_now;
        shift_out <= {shift_out[14:0], 1'b0};
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == 4'hF)
        begin
          word_done <= 1'b1;
          if (!word_now[15])
          begin
            shift_out <= read_data;
            rd_diag <= ({wa[6:1], 1'b0} == `ADR_DIAG);
          end
          else
          begin
            case ({wa[6:1], 1'b0})
              `ADR_X_OFF:  x_off <= put_byte(x_off, wa[0], wd);
              `ADR_Y_OFF:  y_off <= put_byte(y_off, wa[0], wd);
              `ADR_Z_OFF:  z_off <= put_byte(z_off, wa[0], wd);
              `ADR_ALARM:  alarm_routing_control <=
                             put_byte(alarm_routing_control, wa[0], wd);
              `ADR_GPIO:   general_line_control <=
                             put_byte(general_line_control, wa[0], wd);
              `ADR_MISC:   misc_control <= put_byte(misc_control, wa[0], wd);
              `ADR_PERIOD: sample_period <=
                             put_byte(sample_period, wa[0], wd);
              `ADR_CMD:
              begin
                global_command <= wa[0] ? {wd[0], 8'h0} : {1'b0, wd};
                cmd_pulse <= wa[0] ? {wd[0], 8'h0} : {1'b0, wd};
                if (next_pause != 27'h0)
                begin
                  busy <= 1'b1;
                  pause_cnt <= next_pause;
                end
                if (!wa[0] && wd[`CMD_STANDBY])
                  standby <= 1'b1;
                if (wa[0] && wd[0])
                  standby <= 1'b0;
              end
              default: ;
            endcase
          end
        end
      end
    end
  end

  // ==========================================================
  // Sample rate divider: base tick then divisor
  reg  [15:0] base_cnt;   // Clock cycles per base tick
  reg  [15:0] rate_cnt;   // Base ticks per sample
  wire [15:0] rate_divisor = sample_period;

  // Sampling halts in standby and during pauses
  always @(posedge clk)
  begin
    if (rst)
    begin
      base_cnt <= 16'h0;
      rate_cnt <= 16'h0;
      sample_tick <= 1'b0;
    end
    else
    begin
      sample_tick <= 1'b0;
      if (!busy && !standby && !pause_start)
      begin
        if (base_cnt == BASE_DIV[15:0] - 16'h1)
        begin
          base_cnt <= 16'h0;
          if (rate_cnt >= rate_divisor)
          begin
            rate_cnt <= 16'h0;
            sample_tick <= 1'b1;
          end
          else
            rate_cnt <= rate_cnt + 16'h1;
        end
        else
          base_cnt <= base_cnt + 16'h1;
      end
    end
  end

  // ==========================================================
  // Diagnostic flags, set beats clear
  wire [15:0] flag_set = {6'h0, alarm2, alarm1, buffer_full, checksum_bad,
                          selftest_fail, selftest_busy, 1'b0, nv_fail,
                          supply_over & sample_tick, supply_under & sample_tick};
  reg         spi_err;    // Bad clock count at deselect

  // Flags clear on read or clear command
  always @(posedge clk)
  begin
    if (rst)
    begin
      diagnostic_flags <= `RST_ZERO;
      spi_err <= 1'b0;
    end
    else
    begin
      spi_err <= cs_rise && bit_cnt != 4'h0;
      if (rd_diag || cmd_pulse[`CMD_CLRDIAG])
        diagnostic_flags <= flag_set | {12'h0, spi_err, 3'h0};
      else
        diagnostic_flags <= diagnostic_flags | flag_set
                            | {12'h0, spi_err, 3'h0};
    end
  end

  // ==========================================================
  // Line drivers and control outputs
  reg dr_pulse; // Data-ready level, set by a sample, cleared when a serial word completes

  // Outputs from control registers
  always @(posedge clk)
  begin
    if (rst)
    begin
      dr_pulse <= 1'b0;
      data_ready <= 1'b0;
      line1_out <= 1'b0;
      line1_oe <= 1'b0;
      line2_out <= 1'b0;
      line2_oe <= 1'b0;
      selftest_apply <= 1'b0;
      selftest_skip <= 1'b0;
      peak_sum_en <= 1'b0;
      peak_axis_en <= 1'b0;
      x_trim <= 10'h0;
      y_trim <= 10'h0;
      z_trim <= 10'h0;
    end
    else
    begin
      if (sample_tick)
        dr_pulse <= 1'b1;
      else if (word_done)
        dr_pulse <= 1'b0;
      data_ready <= dr_pulse;
      selftest_apply <= misc_control[`MS_ST_EN];
      selftest_skip <= misc_control[`MS_ST_SKIP];
      peak_sum_en <= misc_control[`MS_PK_SUM];
      peak_axis_en <= misc_control[`MS_PK_AXIS];
      x_trim <= x_off[9:0];
      y_trim <= y_off[9:0];
      z_trim <= z_off[9:0];
      // data-ready first, then alarm (line one only), then general purpose
      if (misc_control[`MS_DR_EN] && !misc_control[`MS_DR_SEL])
      begin
        line1_oe <= 1'b1;
        line1_out <= ~(dr_pulse ^ misc_control[`MS_DR_POL]);
      end
      else if (alarm_routing_control[2:0] == `ALM_LINE1_HI)
      begin
        line1_oe <= 1'b1;
        line1_out <= alarm1;
      end
      else
      begin
        line1_oe <= general_line_control[`GP_DIR1];
        line1_out <= general_line_control[`GP_LVL1];
      end
      if (misc_control[`MS_DR_EN] && misc_control[`MS_DR_SEL])
      begin
        line2_oe <= 1'b1;
        line2_out <= ~(dr_pulse ^ misc_control[`MS_DR_POL]);
      end
      else
      begin
        line2_oe <= general_line_control[`GP_DIR2];
        line2_out <= general_line_control[`GP_LVL2];
      end
    end
  end
endmodule

// ===== logic/sensor_operational_control_regs.vh
`ifndef SENSOR_OPERATIONAL_CONTROL_REGS_VH
`define SENSOR_OPERATIONAL_CONTROL_REGS_VH
// ==========================================================
// Register byte addresses (low byte of each register)
`define ADR_DIAG      7'h1A
`define ADR_X_OFF     7'h20
`define ADR_Y_OFF     7'h22
`define ADR_Z_OFF     7'h24
`define ADR_ALARM     7'h3C
`define ADR_GPIO      7'h44
`define ADR_MISC      7'h46
`define ADR_PERIOD    7'h48
`define ADR_CMD       7'h4A
// ==========================================================
// Reset values
`define RST_MISC      16'h0006
`define RST_PERIOD    16'h001F
`define RST_ZERO      16'h0000
// ==========================================================
// Command bit positions
`define CMD_AUTONULL  0
`define CMD_FACTORY   1
`define CMD_STANDBY   2
`define CMD_SAVE      3
`define CMD_CLRDIAG   4
`define CMD_CLRPEAK   5
`define CMD_ERASE     6
`define CMD_SWRESET   7
`define CMD_WAKE      8
// ==========================================================
// Diagnostic flag positions
`define DG_UNDER      0
`define DG_OVER       1
`define DG_NVFAIL     2
`define DG_SPI        3
`define DG_STBUSY     4
`define DG_STFAIL     5
`define DG_CHKSUM     6
`define DG_BUFFULL    7
`define DG_ALM1       8
`define DG_ALM2       9
// ==========================================================
// Field positions
`define MS_DR_SEL     0
`define MS_DR_POL     1
`define MS_DR_EN      2
`define MS_ST_EN      8
`define MS_ST_SKIP    9
`define MS_PK_AXIS    14
`define MS_PK_SUM     15
`define GP_DIR1       0
`define GP_DIR2       1
`define GP_LVL1       8
`define GP_LVL2       9
`define ALM_LINE1_HI  3'b110
// ==========================================================
// Timing
`define BASE_HZ       32768
`define CLK_HZ        200000000
`define T_WAKE_US     200
`define T_RESET_US    32000
`define T_SAVE_US     24000
`define T_LONG_US     350000
`define CLK_PER_US    200
`endif

// ===== bench/spi_host_model.sv
`timescale 1ns/1ps
// ==========================================
// Host master model, link clock idles high
module spi_host_model #(
  parameter int HALF = 32  // Half of the 64 ns link period
) (
  output logic sclk,  // Link clock, still between frames
  output logic cs_n,  // Select, active low
  output logic mosi,  // Host data
  input  wire  miso   // Device data
);
  // Idle levels before the first frame
  initial
  begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  // Sends nb bits MSB first, gathers the device bits at each rise
  task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] r);
    int i;
    r = 16'h0000;
    cs_n = 1'b0;
    #(HALF);
    for (i = 0; i < nb; i++)
    begin
      sclk = 1'b0;
      mosi = w[15 - i];
      #(HALF);
      sclk = 1'b1;
      r = {r[14:0], miso};
      #(HALF);
    end
    cs_n = 1'b1;
    mosi = ~mosi; // Released line must not keep its last value
    #(HALF);
  endtask
endmodule

// ===== bench/sensor_operational_control_sva.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the control register block
module soc_checker #(
  parameter integer WAKE_CYC  = 20,
  parameter integer RESET_CYC = 50,
  parameter integer SAVE_CYC  = 40,
  parameter integer LONG_CYC  = 100,
  parameter integer BASE_DIV  = 4
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       sample_tick,
  input wire logic       data_ready,
  input wire logic       standby,
  input wire logic       busy,
  input wire logic [8:0] cmd_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Helper counters
  logic [31:0] gap;   // Cycles since the last sample
  logic        seen;  // A sample came since reset
  logic [31:0] blen;  // Length of the running pause
  logic [8:0]  last;  // Commands of the latest write
  // Counts are cleared by reset so no stale pause is judged
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gap  <= 32'h0;
      seen <= 1'b0;
      blen <= 32'h0;
      last <= 9'h000;
    end
    else
    begin
      gap  <= sample_tick ? 32'h1 : gap + 32'h1;
      seen <= seen | sample_tick;
      blen <= busy ? blen + 32'h1 : 32'h0;
      last <= (cmd_pulse != 9'h000) ? cmd_pulse : last;
    end
  end
  // Pause owed to the latest commands; the longest one dominates
  function automatic integer want(input logic [8:0] c);
    if (c[6] || c[1])
      return LONG_CYC;
    if (c[7])
      return RESET_CYC;
    if (c[3])
      return SAVE_CYC;
    if (c[8])
      return WAKE_CYC;
    return 0;
  endfunction
  // ==========================================
  // Sequences and assertions
  sequence pause_soon;
    ##[0:3] busy;
  endsequence
  sequence pause_ends;
    $fell(busy) && (blen != 32'h0);
  endsequence
  a_pulse_one_cycle: assert property ((cmd_pulse != 9'h000) |=> (cmd_pulse == 9'h000))
    else $error("command pulse longer than one cycle");
  a_reset_pauses: assert property (cmd_pulse[7] |-> pause_soon)
    else $error("software reset without pause");
  a_long_pauses: assert property ((cmd_pulse[6] || cmd_pulse[1]) |-> pause_soon)
    else $error("long command without pause");
  a_save_pauses: assert property (cmd_pulse[3] |-> pause_soon)
    else $error("save command without pause");
  a_pause_length: assert property (pause_ends |-> (blen + 1 >= want(last)) && (blen <= want(last) + 3))
    else $error("pause length wrong");
  a_no_sample_paused: assert property (busy |-> !sample_tick)
    else $error("sample taken during pause");
  a_tick_spacing: assert property ((sample_tick && seen) |-> (gap >= BASE_DIV))
    else $error("samples too close");
  a_standby_enter: assert property (cmd_pulse[2] |-> ##[1:3] standby)
    else $error("standby not entered");
  a_wake_leaves: assert property ((pause_ends and last[8]) |-> ##[0:2] !standby)
    else $error("standby kept after wake");
  a_ready_from_tick: assert property ($rose(data_ready) |-> $past(sample_tick, 2))
    else $error("data ready without sample");
endmodule

bind sensor_operational_control soc_checker #(
  .WAKE_CYC(WAKE_CYC), .RESET_CYC(RESET_CYC), .SAVE_CYC(SAVE_CYC), .LONG_CYC(LONG_CYC),
  .BASE_DIV(BASE_DIV)
) chk_u (
  .clk(clk), .rst(rst), .sample_tick(sample_tick), .data_ready(data_ready),
  .standby(standby), .busy(busy), .cmd_pulse(cmd_pulse)
);

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", what, exp, got); end end
module tb_top;
  // ==========================================
  // Clock, reset, stimulus and monitors
  logic       clk = 1'b0;        // 200 MHz clock
  logic       rst = 1'b1;        // Synchronous reset
  logic [9:0] cond = 10'h000;    // Fault inputs, by flag position
  logic [1:0] lines_in = 2'b00;  // Line input levels
  logic [8:0] seen_cmd = 9'h000; // Command pulses gathered
  int         blen = 0;          // Busy cycles counted
  int         cyc = 0;           // Cycles run
  int         err_count = 0;
  int         n_tests = 0;
  wire        sclk, cs_n, mosi, miso, line1_out, line1_oe, line2_out, line2_oe;
  wire        sample_tick, data_ready, standby, busy;
  wire        selftest_apply, selftest_skip, peak_sum_en, peak_axis_en;
  wire [8:0]  cmd_pulse;
  wire [9:0]  x_trim, y_trim, z_trim;
  always #2.5 clk = ~clk;
  // Short counts keep pauses and sample periods brief
  sensor_operational_control #(.WAKE_CYC(20), .RESET_CYC(50), .SAVE_CYC(40),
    .LONG_CYC(100), .BASE_DIV(4)) dut_u (
    .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .supply_over(cond[1]), .supply_under(cond[0]), .checksum_bad(cond[6]),
    .alarm1(cond[8]), .alarm2(cond[9]), .buffer_full(cond[7]), .selftest_fail(cond[5]),
    .selftest_busy(cond[4]), .nv_fail(cond[2]),
    .line1_in(lines_in[0]), .line2_in(lines_in[1]),
    .line1_out(line1_out), .line1_oe(line1_oe), .line2_out(line2_out), .line2_oe(line2_oe),
    .sample_tick(sample_tick), .data_ready(data_ready), .standby(standby), .busy(busy),
    .cmd_pulse(cmd_pulse), .selftest_apply(selftest_apply), .selftest_skip(selftest_skip),
    .peak_sum_en(peak_sum_en), .peak_axis_en(peak_axis_en),
    .x_trim(x_trim), .y_trim(y_trim), .z_trim(z_trim));
  spi_host_model spi_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
  // Gathers pulses and pause time; cuts a hang short
  always @(posedge clk)
  begin
    cyc++;
    seen_cmd = seen_cmd | cmd_pulse;
    if (busy === 1'b1)
      blen++;
    if (cyc == 80000)
    begin
      err_count++;
      finish_test();
    end
  end
  // ==========================================
  // Bus and timing helpers
  task automatic wr(input logic [15:0] w);
    logic [15:0] r;
    int i;
    spi_u.xfer(w, 16, r);
    repeat (10) @(negedge clk);
    for (i = 0; i < 1000 && busy === 1'b1; i++) @(negedge clk);
    // Copied outputs follow their registers one edge later
    repeat (2) @(negedge clk);
  endtask
  // Data of a read comes back in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    logic [15:0] r;
    spi_u.xfer({1'b0, a, 8'h00}, 16, r);
    spi_u.xfer(16'h4800, 16, d);
  endtask
  task automatic after_tick();
    int i;
    for (i = 0; i < 6000 && sample_tick !== 1'b1; i++) @(negedge clk);
    repeat (3) @(negedge clk);
  endtask
  task automatic tick_gap(output int n);
    int i;
    for (i = 0; i < 6000 && sample_tick !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    for (n = 1; n < 6000 && sample_tick !== 1'b1; n++) @(negedge clk);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_defaults();
    logic [6:0]  a[7] = '{7'h48, 7'h46, 7'h44, 7'h20, 7'h22, 7'h24, 7'h1A};
    logic [15:0] e[7] = '{16'h001F, 16'h0006, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] d;
    int k;
    for (k = 0; k < 7; k++)
    begin
      rd(a[k], d);
      `CHK("reset value", e[k], d)
    end
  endtask
  task automatic t_rate();
    logic [15:0] d;
    int n;
    tick_gap(n);
    `CHK("default period", 32 * 4, n)
    wr(16'hC807);
    tick_gap(n);
    tick_gap(n);
    `CHK("fastest period", 8 * 4, n)
    wr(16'hC901);
    rd(7'h48, d);
    `CHK("divisor width", 16'h0107, d)
    tick_gap(n);
    tick_gap(n);
    `CHK("wide period", 264 * 4, n)
    wr(16'hC900);
  endtask
  task automatic t_trims();
    wr(16'hA0FF);
    wr(16'hA103);
    wr(16'hA20A);
    wr(16'hA5FF);
    `CHK("trims", {10'h3FF, 10'h00A, 10'h300}, {x_trim, y_trim, z_trim})
  endtask
  task automatic t_misc();
    wr(16'hC7C3);
    `CHK("misc all", 4'hF, {peak_sum_en, peak_axis_en, selftest_skip, selftest_apply})
    wr(16'hC780);
    `CHK("misc sum", 4'h8, {peak_sum_en, peak_axis_en, selftest_skip, selftest_apply})
  endtask
  task automatic t_lines();
    wr(16'hC604);
    after_tick();
    `CHK("ready low line1", 3'b101, {line1_oe, line1_out, data_ready})
    wr(16'hC607);
    after_tick();
    `CHK("ready high line2", 2'b11, {line2_oe, line2_out})
    wr(16'hC403);
    wr(16'hC501);
    after_tick();
    `CHK("general out", 3'b111, {line1_oe, line1_out, line2_out})
    wr(16'hBC06);
    cond[8] = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("alarm high", 1'b1, line1_out)
    cond[8] = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("alarm over level", 2'b10, {line1_oe, line1_out})
    wr(16'hC606);
    after_tick();
    `CHK("ready over alarm", 3'b110, {line1_out, line2_oe, line2_out})
    wr(16'hC600);
    wr(16'hBC00);
    wr(16'hC401);
    `CHK("direction", 3'b110, {line1_oe, line1_out, line2_oe})
  endtask
  task automatic t_commands();
    int bits[9] = '{0, 3, 4, 5, 2, 8, 6, 1, 7};
    int pause[9] = '{0, 40, 0, 0, 0, 20, 100, 100, 50};
    logic [15:0] d;
    int k;
    for (k = 0; k < 9; k++)
    begin
      if (bits[k] == 7)
        wr(16'hA0FF);
      seen_cmd = 9'h000;
      blen = 0;
      wr(bits[k] == 8 ? 16'hCB01 : {8'hCA, 8'h01 << bits[k]});
      `CHK("command pulse", 1'b1, seen_cmd[bits[k]])
      `CHK("pause fits", 1'b1, (blen + 1 >= pause[k]) && (blen <= pause[k] + 3))
      `CHK("standby", (bits[k] == 2), standby)
    end
    `CHK("reset trims", 10'h000, x_trim)
    `CHK("reset misc", 1'b0, peak_sum_en)
    rd(7'h48, d);
    `CHK("reset divisor", 16'h001F, d)
    rd(7'h4A, d);
    `CHK("command reads", 16'h0000, d)
  endtask
  task automatic t_diag();
    logic [15:0] d, r;
    rd(7'h1A, d);
    cond = 10'h3F7;
    after_tick();
    cond = 10'h000;
    rd(7'h1A, d);
    `CHK("flags set", 16'h03F7, d)
    rd(7'h1A, d);
    `CHK("flags cleared", 16'h0000, d)
    cond = 10'h002;
    after_tick();
    rd(7'h1A, d);
    after_tick();
    rd(7'h1A, d);
    `CHK("supply again", 16'h0002, d)
    cond = 10'h000;
    rd(7'h1A, d);
    spi_u.xfer(16'h0000, 12, r);
    rd(7'h1A, d);
    `CHK("short frame", 16'h0008, d)
    cond = 10'h004;
    after_tick();
    cond = 10'h000;
    wr(16'hCA10);
    rd(7'h1A, d);
    `CHK("clear command", 16'h0000, d)
  endtask
  // ==========================================
  // Verdict and main sequence
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_defaults();
    t_rate();
    t_trims();
    t_misc();
    t_lines();
    t_commands();
    t_diag();
    finish_test();
  end
endmodule
